// ==== logic/rsw_reset_state.sv ====
// Reset-state logic with wake status flags behind a classic Wishbone slave
//
// Register access over Wishbone was left to the implementer.
`timescale 1ns/10ps

module rsw_reset_state
    import rsw_pkg::*;
#(
    parameter int RAM_WORDS = 48  // Data registers 0x10..0x3F
) (
    input  wire logic        clk_i,       // Core clock, 20 MHz
    input  wire logic        rst_i,       // Power-on reset, sync, active high
    input  wire logic        ce_i,        // Clock enable, freezes all state
    input  wire logic        ext_rst_i,   // External pin reset release pulse
    input  wire logic        wdt_rst_i,   // Watchdog reset release pulse
    input  wire logic        wake_i,      // Wake-up from sleep or idle pulse
    input  wire logic        wdt_clr_i,   // Watchdog clear instruction executed
    input  wire logic        sleep_i,     // Sleep instruction executed
    input  wire logic        wdt_tmo_i,   // Watchdog time-out event
    input  wire logic        wb_cyc_i,    // Wishbone cycle
    input  wire logic        wb_stb_i,    // Wishbone strobe
    input  wire logic        wb_we_i,     // Wishbone write enable
    input  wire logic [9:0]  wb_adr_i,    // Wishbone byte address
    input  wire logic [3:0]  wb_sel_i,    // Wishbone byte selects
    input  wire logic [31:0] wb_dat_i,    // Wishbone write data
    output logic      [31:0] wb_dat_o,    // Wishbone read data
    output logic             wb_ack_o,    // Wishbone acknowledge
    output logic             time_out_o,  // Time-out flag
    output logic             power_down_o // Power-down flag
);

    // ==========================================================
    // Elaboration checks
    // ==========================================================
    if (RAM_WORDS != 48) begin : g_bad_ram
        $error("RAM_WORDS must cover 0x10 to 0x3F");
    end

    // ==========================================================
    // State
    // ==========================================================
    logic [7:0] uc1_q;            // Uart control one
    logic [7:0] uc2_q;            // Uart control two
    logic [7:0] urs_q;            // Uart receive status
    logic [7:0] urx_q;            // Uart receive buffer
    logic [7:0] utx_q;            // Uart transmit buffer
    logic [7:0] sc1_q;            // Serial control one
    logic [7:0] sc2_q;            // Serial control two
    logic [7:0] sdat_q;           // Serial data
    logic [7:0] pua_q;            // Pull-up a
    logic [7:0] pda_q;            // Pull-down a
    logic [7:0] pub_q;            // Pull-up b
    logic [7:0] pdb_q;            // Pull-down b
    logic       t_q;              // Time-out flag
    logic       p_q;              // Power-down flag
    logic       ack_q;            // Bus answer
    logic [31:0] rdat_q;          // Registered read data
    logic [7:0] ram_q [RAM_WORDS];// Data registers, no reset

    // ==========================================================
    // Decode
    // ==========================================================
    wire  [7:0] idx     = wb_adr_i[9:2];                 // Word index
    wire        req     = wb_cyc_i & wb_stb_i & ~ack_q;  // New request
    wire        wr      = req & wb_we_i & wb_sel_i[0];   // Low lane write
    wire  [7:0] wd      = wb_dat_i[7:0];                 // Write byte
    wire        hard    = ext_rst_i | wdt_rst_i;         // Pin or watchdog
    wire        in_ram  = (idx >= REG_RAM_FIRST) && (idx <= REG_RAM_LAST);
    wire  [5:0] ram_ix  = 6'(idx - REG_RAM_FIRST);       // Array index

    // Address match for one register index
    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        return a == r;
    endfunction

    // Next value of a control byte: reset effects beat bus writes
    function automatic logic [7:0] nxt(input logic [7:0] cur, input logic w,
                                       input logic [7:0] d, input logic h,
                                       input logic [7:0] hclr, input logic [7:0] hset,
                                       input logic k, input logic [7:0] kclr);
        logic [7:0] v;
        v = w ? d : cur;
        if (h) begin
            v = (cur & ~hclr) | hset;
        end else if (k) begin
            v = cur & ~kclr;
        end
        return v;
    endfunction

    // Read mux, reserved bits read zero
    logic [7:0] rd_byte;
    always_comb begin
        rd_byte = BYTE_ZERO;
        case (idx)
            REG_STATUS:       rd_byte = {3'h0, t_q, p_q, 3'h0};
            REG_UART_CTRL1:   rd_byte = uc1_q;
            REG_UART_CTRL2:   rd_byte = uc2_q & UC2_MASK;
            REG_UART_RX_STAT: rd_byte = urs_q;
            REG_UART_RX_BUF:  rd_byte = urx_q;
            REG_UART_TX_BUF:  rd_byte = utx_q;
            REG_PULLUP_A:     rd_byte = pua_q & PULL_A_SET;
            REG_PULLDOWN_A:   rd_byte = pda_q & PULL_A_SET;
            REG_PULLUP_B:     rd_byte = pub_q & PULL_B_SET;
            REG_PULLDOWN_B:   rd_byte = pdb_q & PULL_B_SET;
            REG_SERIAL_CTRL1: rd_byte = sc1_q;
            REG_SERIAL_CTRL2: rd_byte = sc2_q & SC2_MASK;
            REG_SERIAL_DATA:  rd_byte = sdat_q;
            default:          rd_byte = in_ram ? ram_q[ram_ix] : BYTE_ZERO;
        endcase
    end

    // ==========================================================
    // Bus answer, one cycle after request
    // ==========================================================
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q  <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else if (ce_i) begin
            ack_q  <= req;
            rdat_q <= {24'h00_0000, rd_byte};
        end
    end
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    // ==========================================================
    // Time-out and power-down flags
    // ==========================================================
    // Priority: resets, then instructions; wake leaves both as they are
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            t_q <= 1'b1;
            p_q <= 1'b1;
        end else if (ce_i) begin
            if (wdt_rst_i || wdt_tmo_i) begin
                t_q <= 1'b0;
            end else if (ext_rst_i) begin
                t_q <= t_q;
            end else if (wdt_clr_i) begin
                t_q <= 1'b1;
                p_q <= 1'b1;
            end else if (sleep_i) begin
                t_q <= 1'b1;
                p_q <= 1'b0;
            end
        end
    end
    assign time_out_o   = t_q;
    assign power_down_o = p_q;

    // ==========================================================
    // Peripheral control registers
    // ==========================================================
    // effects land in the release cycle, before first fetch
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            uc1_q <= UC1_POR;
            uc2_q <= BYTE_ZERO;
            urs_q <= BYTE_ZERO;
            sc1_q <= BYTE_ZERO;
            sc2_q <= BYTE_ZERO;
            pua_q <= PULL_A_SET;
            pda_q <= PULL_A_SET;
            pub_q <= PULL_B_SET;
            pdb_q <= PULL_B_SET;
        end else if (ce_i) begin
            uc1_q <= nxt(uc1_q, wr && hit(idx, REG_UART_CTRL1), wd, hard,
                         UC1_HARD_CLR, BYTE_ZERO, wake_i, UC1_WAKE_CLR);
            urs_q <= nxt(urs_q, wr && hit(idx, REG_UART_RX_STAT), wd, hard,
                         URS_HARD_CLR, BYTE_ZERO, wake_i, URS_WAKE_CLR);
            sc1_q <= nxt(sc1_q, wr && hit(idx, REG_SERIAL_CTRL1), wd, hard,
                         SC1_HARD_CLR, BYTE_ZERO, 1'b0, BYTE_ZERO);
            sc2_q <= nxt(sc2_q, wr && hit(idx, REG_SERIAL_CTRL2), wd, hard,
                         SC2_HARD_CLR, BYTE_ZERO, wake_i, SC2_WAKE_CLR);
            uc2_q <= nxt(uc2_q, wr && hit(idx, REG_UART_CTRL2), wd, 1'b0,
                         BYTE_ZERO, BYTE_ZERO, 1'b0, BYTE_ZERO);
            pua_q <= nxt(pua_q, wr && hit(idx, REG_PULLUP_A), wd, hard,
                         BYTE_ZERO, PULL_A_SET, 1'b0, BYTE_ZERO);
            pda_q <= nxt(pda_q, wr && hit(idx, REG_PULLDOWN_A), wd, hard,
                         BYTE_ZERO, PULL_A_SET, 1'b0, BYTE_ZERO);
            pub_q <= nxt(pub_q, wr && hit(idx, REG_PULLUP_B), wd, hard,
                         BYTE_ZERO, PULL_B_SET, 1'b0, BYTE_ZERO);
            pdb_q <= nxt(pdb_q, wr && hit(idx, REG_PULLDOWN_B), wd, hard,
                         BYTE_ZERO, PULL_B_SET, 1'b0, BYTE_ZERO);
        end
    end

    // ==========================================================
    // Data buffers and general-purpose registers, never reset
    // ==========================================================
    // Unknown at power-up by nature; no reset keeps them cheap
    always_ff @(posedge clk_i) begin
        if (ce_i) begin
            if (wr && in_ram) begin
                ram_q[ram_ix] <= wd;
            end
            if (wr && hit(idx, REG_UART_TX_BUF)) begin
                utx_q <= wd;
            end
            if (wr && hit(idx, REG_SERIAL_DATA)) begin
                sdat_q <= wd;
            end
            // Receive buffer has no load path here; it only holds its value
            urx_q <= urx_q;
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    property p_por_flags;
        @(posedge clk_i) $fell(rst_i) |-> (t_q && p_q);
    endproperty
    a_por_flags: assert property (p_por_flags) else $error("flags not set by power-on");

    property p_ext_keep;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && ext_rst_i && !wdt_rst_i && !wdt_tmo_i) |=> $stable(t_q) && $stable(p_q);
    endproperty
    a_ext_keep: assert property (p_ext_keep) else $error("pin reset changed flags");

    property p_wdt_flags;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && (wdt_rst_i || wdt_tmo_i)) |=> !t_q && $stable(p_q);
    endproperty
    a_wdt_flags: assert property (p_wdt_flags) else $error("watchdog flag effect wrong");

    property p_sleep;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && sleep_i && !wdt_clr_i && !hard && !wdt_tmo_i) |=> t_q && !p_q;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep flag effect wrong");

    property p_wake_keep;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && wake_i && !hard && !wdt_tmo_i && !wdt_clr_i && !sleep_i)
        |=> $stable(t_q) && $stable(p_q);
    endproperty
    a_wake_keep: assert property (p_wake_keep) else $error("wake changed flags");

    property p_hard_bits;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && hard) |=> ((uc1_q & UC1_HARD_CLR) == 8'h00) && (pua_q[5:0] == 6'h3F)
                           && ((sc2_q & SC2_HARD_CLR) == 8'h00);
    endproperty
    a_hard_bits: assert property (p_hard_bits) else $error("hard reset bits wrong");

    property p_wake_bits;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && wake_i && !hard) |=> !uc1_q[6] && !uc1_q[0] && !urs_q[0] && !sc2_q[7]
                                      && (uc1_q[5:1] == $past(uc1_q[5:1]));
    endproperty
    a_wake_bits: assert property (p_wake_bits) else $error("wake bits wrong");

    property p_ack;
        @(posedge clk_i) disable iff (rst_i)
        // A frozen edge after the answer keeps ack up for one more cycle
        (ce_i && req) |=> wb_ack_o ##1 (!wb_ack_o || !$past(ce_i));
    endproperty
    a_ack: assert property (p_ack) else $error("bus answer timing wrong");

    property p_clr_flags;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && wdt_clr_i && !hard && !wdt_tmo_i) |=> t_q && p_q;
    endproperty
    a_clr_flags: assert property (p_clr_flags) else $error("clear flag effect wrong");

    // pull-down and bank b disables
    // Every pull bank, not only pull-up a, must land at its disable level
    property p_pull_hard;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && hard) |=> ((pda_q & PULL_A_SET) == PULL_A_SET)
                           && ((pub_q & PULL_B_SET) == PULL_B_SET)
                           && ((pdb_q & PULL_B_SET) == PULL_B_SET);
    endproperty
    a_pull_hard: assert property (p_pull_hard) else $error("pull disable bits not set");

    // configuration bits kept
    // A bus write in the same cycle may legally change control two, so it is excluded
    property p_keep_cfg;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && (hard || wake_i) && !wr) |=> $stable(uc2_q) && $stable(uc1_q[7])
                                             && (uc1_q[5:2] == $past(uc1_q[5:2]));
    endproperty
    a_keep_cfg: assert property (p_keep_cfg) else $error("kept bits changed");

endmodule // rsw_reset_state

// ==== logic/rsw_pkg.sv ====
// Package with register map, field positions and reset values of the reset-state block
package rsw_pkg;

    // ==========================================================
    // Register word indices (byte address = index * 4)
    // ==========================================================
    localparam logic [7:0] REG_UART_CTRL1    = 8'h05; // Uart control one
    localparam logic [7:0] REG_UART_CTRL2    = 8'h06; // Uart control two
    localparam logic [7:0] REG_UART_RX_STAT  = 8'h07; // Uart receive status
    localparam logic [7:0] REG_UART_RX_BUF   = 8'h08; // Uart receive buffer
    localparam logic [7:0] REG_UART_TX_BUF   = 8'h09; // Uart transmit buffer
    localparam logic [7:0] REG_PULLUP_A      = 8'h0A; // Pull-up control a
    localparam logic [7:0] REG_PULLDOWN_A    = 8'h0B; // Pull-down control a
    localparam logic [7:0] REG_PULLUP_B      = 8'h0C; // Pull-up control b
    localparam logic [7:0] REG_PULLDOWN_B    = 8'h0D; // Pull-down control b
    localparam logic [7:0] REG_RAM_FIRST     = 8'h10; // First data register
    localparam logic [7:0] REG_RAM_LAST      = 8'h3F; // Last data register
    localparam logic [7:0] REG_SERIAL_CTRL1  = 8'h45; // Serial port control one
    localparam logic [7:0] REG_SERIAL_CTRL2  = 8'h46; // Serial port control two
    localparam logic [7:0] REG_SERIAL_DATA   = 8'h47; // Serial port data
    localparam logic [7:0] REG_STATUS        = 8'h03; // Time-out and power-down flags

    // ==========================================================
    // Status field positions
    // ==========================================================
    localparam int STAT_POWER_DOWN = 3; // Power-down flag
    localparam int STAT_TIME_OUT   = 4; // Time-out flag

    // ==========================================================
    // Bits forced by an external or watchdog reset
    // ==========================================================
    localparam logic [7:0] UC1_HARD_CLR  = 8'h03; // Tx buffer empty, tx enable
    localparam logic [7:0] URS_HARD_CLR  = 8'h1F; // Errors, rx full, rx enable
    localparam logic [7:0] SC1_HARD_CLR  = 8'h01; // Write buffer empty
    localparam logic [7:0] SC2_HARD_CLR  = 8'h81; // Start, buffer full
    localparam logic [7:0] PULL_A_SET    = 8'h3F; // Disable bits of bank a
    localparam logic [7:0] PULL_B_SET    = 8'h0F; // Disable bits of bank b

    // ==========================================================
    // Bits cleared on wake-up
    // ==========================================================
    localparam logic [7:0] UC1_WAKE_CLR  = 8'h41; // Format upper, tx enable
    localparam logic [7:0] URS_WAKE_CLR  = 8'h01; // Rx enable
    localparam logic [7:0] SC2_WAKE_CLR  = 8'h80; // Start

    // ==========================================================
    // Power-on values and implemented-bit masks
    // ==========================================================
    localparam logic [7:0] UC1_POR       = 8'h00; // Power-on value
    localparam logic [7:0] UC2_MASK      = 8'h38; // Implemented bits of control two
    localparam logic [7:0] SC2_MASK      = 8'h87; // Implemented bits of serial two
    localparam logic [7:0] BYTE_ZERO     = 8'h00; // All clear

    // Reset causes
    typedef enum logic [2:0] {
        RSW_EV_NONE,
        RSW_EV_POWER_ON,
        RSW_EV_EXT_PIN,
        RSW_EV_WATCHDOG,
        RSW_EV_WAKE
    } rsw_event_t;

endpackage

// ==== test/rsw_reset_state_bench.sv ====
// Self-checking bench for the reset-state block over classic Wishbone
`timescale 1ns/10ps
module rsw_reset_state_bench;
    import rsw_pkg::*;
    // ==========================================================
    // Stimulus signals
    // ==========================================================
    logic        clk_i = 1'b0;   // Core clock
    logic        rst_i = 1'b1;   // Power-on reset
    logic        ce_i  = 1'b1;   // Clock enable
    logic [5:0]  ev_q  = 6'h00;  // Ext, wdt rst, wake, clear, sleep, timeout
    logic        cyc_q = 1'b0;   // Bus cycle
    logic        stb_q = 1'b0;   // Bus strobe
    logic        we_q  = 1'b0;   // Bus direction
    logic [9:0]  adr_q = 10'h000; // Byte address
    logic [3:0]  sel_q = 4'h0;   // Byte selects
    logic [31:0] dat_q = 32'h0;  // Write data
    wire  [31:0] wb_dat_o;       // Read data
    wire         wb_ack_o;       // Acknowledge
    wire         time_out_o;     // Time-out flag
    wire         power_down_o;   // Power-down flag
    int          fail_count = 0; // Mismatches
    int          checks = 0;     // Comparisons
    // Half period of 25 ns gives 20 MHz
    always #25 clk_i = ~clk_i;
    rsw_reset_state rsw_reset_state_i (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
        .ext_rst_i(ev_q[5]), .wdt_rst_i(ev_q[4]), .wake_i(ev_q[3]),
        .wdt_clr_i(ev_q[2]), .sleep_i(ev_q[1]), .wdt_tmo_i(ev_q[0]),
        .wb_cyc_i(cyc_q), .wb_stb_i(stb_q), .wb_we_i(we_q), .wb_adr_i(adr_q),
        .wb_sel_i(sel_q), .wb_dat_i(dat_q), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .time_out_o(time_out_o), .power_down_o(power_down_o));
    // ==========================================================
    // Shared tasks
    // ==========================================================
    task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", n, exp, seen);
        end
    endtask
    // Verdict and end of run, shared with the watchdog
    task automatic close_out();
        $display("Checks %0d, mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // One classic cycle; holds everything until ack is sampled high
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d,
                       input logic [3:0] s, output logic [31:0] q);
        @(posedge clk_i);
        cyc_q <= 1'b1;
        stb_q <= 1'b1;
        we_q  <= w;
        adr_q <= {idx, 2'b00};
        sel_q <= s;
        dat_q <= {24'h0, d};
        // No latency assumed; only the watchdog ends a hang
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        cyc_q <= 1'b0;
        stb_q <= 1'b0;
        we_q  <= 1'b0;
        // Ack stands for one cycle only
        @(posedge clk_i);
        check("ack drop", {31'h0, wb_ack_o}, 32'h0);
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, idx, d, 4'hF, q);
    endtask
    // Read, compare the implemented bits and the zero upper bytes
    task automatic rd(input string n, input logic [7:0] idx, input logic [7:0] m,
                      input logic [7:0] exp);
        logic [31:0] q;
        bus(1'b0, idx, 8'h00, 4'hF, q);
        check(n, q & {24'hFFFFFF, m}, {24'h0, exp & m});
    endtask
    // Pulse events for one edge, flags checked in the very next cycle
    task automatic ev(input logic [5:0] m, input logic [1:0] e);
        @(posedge clk_i);
        ev_q <= m;
        @(posedge clk_i);
        ev_q <= 6'h00;
        @(negedge clk_i);
        check("flags", {30'h0, time_out_o, power_down_o}, {30'h0, e});
    endtask
    // ==========================================================
    // Watchdog against a hang
    // ==========================================================
    initial begin
        #(50 * 20000);
        fail_count++;
        close_out();
    end
    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(negedge clk_i);
        check("flags", {30'h0, time_out_o, power_down_o}, 32'h3);
        rd("status", REG_STATUS, 8'h18, 8'h18);
        rd("uc1 por", REG_UART_CTRL1, 8'h7F, 8'h00);
        rd("pull a por", REG_PULLUP_A, 8'h3F, 8'h3F);
        rd("pull b por", REG_PULLDOWN_B, 8'h0F, 8'h0F);
        rd("sc2 por", REG_SERIAL_CTRL2, 8'h87, 8'h00);
        // Load every covered register with known contents
        wr(REG_UART_CTRL1, 8'hFF);
        wr(REG_UART_CTRL2, 8'h38);
        wr(REG_UART_RX_STAT, 8'hFF);
        wr(REG_SERIAL_CTRL1, 8'hFF);
        wr(REG_SERIAL_CTRL2, 8'hFF);
        wr(REG_PULLUP_A, 8'h00);
        wr(REG_PULLDOWN_B, 8'h00);
        wr(REG_RAM_FIRST, 8'hA5);
        wr(REG_RAM_LAST, 8'h5A);
        ev(6'h01, 2'b01);
        rd("status", REG_STATUS, 8'h18, 8'h08);
        ev(6'h02, 2'b10);
        ev(6'h04, 2'b11);
        ev(6'h02, 2'b10);
        ev(6'h08, 2'b10);
        // Wake clears only enables, upper format and start
        rd("uc1 wake", REG_UART_CTRL1, 8'hFF, 8'hBE);
        rd("urs wake", REG_UART_RX_STAT, 8'hFF, 8'hFE);
        rd("sc2 wake", REG_SERIAL_CTRL2, 8'h87, 8'h07);
        rd("pull a wake", REG_PULLUP_A, 8'h3F, 8'h00);
        rd("ram wake", REG_RAM_FIRST, 8'hFF, 8'hA5);
        ev(6'h20, 2'b10);
        // External reset: listed bits cleared, pulls set, rest kept
        rd("uc1 ext", REG_UART_CTRL1, 8'hFF, 8'hBC);
        rd("uc2 ext", REG_UART_CTRL2, 8'h38, 8'h38);
        rd("urs ext", REG_UART_RX_STAT, 8'hFF, 8'hE0);
        rd("sc1 ext", REG_SERIAL_CTRL1, 8'hFF, 8'hFE);
        rd("sc2 ext", REG_SERIAL_CTRL2, 8'h87, 8'h06);
        rd("pull a ext", REG_PULLUP_A, 8'h3F, 8'h3F);
        rd("pull b ext", REG_PULLDOWN_B, 8'h0F, 8'h0F);
        rd("ram ext", REG_RAM_LAST, 8'hFF, 8'h5A);
        // Timeout wins over a clear in the same cycle
        ev(6'h05, 2'b00);
        ev(6'h04, 2'b11);
        wr(REG_PULLUP_A, 8'h00);
        ev(6'h10, 2'b01);
        rd("pull a wdt", REG_PULLUP_A, 8'h3F, 8'h3F);
        rd("ram wdt", REG_RAM_FIRST, 8'hFF, 8'hA5);
        // A frozen clock enable ignores events
        @(posedge clk_i);
        ce_i <= 1'b0;
        ev(6'h04, 2'b01);
        @(posedge clk_i);
        ce_i <= 1'b1;
        // Refused accesses: unmapped, no byte select, read-only flags
        wr(8'h80, 8'h77);
        rd("unmapped", 8'h80, 8'hFF, 8'h00);
        begin
            logic [31:0] q;
            bus(1'b1, REG_UART_CTRL2, 8'h00, 4'hE, q);
        end
        rd("uc2 nosel", REG_UART_CTRL2, 8'h38, 8'h38);
        wr(REG_STATUS, 8'h00);
        rd("status ro", REG_STATUS, 8'h18, 8'h08);
        // Power-on reset again in mid-run, flags start from 0 and 1
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(negedge clk_i);
        check("flags por2", {30'h0, time_out_o, power_down_o}, 32'h3);
        rd("uc1 por2", REG_UART_CTRL1, 8'h7F, 8'h00);
        rd("urs por2", REG_UART_RX_STAT, 8'h7F, 8'h00);
        rd("status por2", REG_STATUS, 8'h18, 8'h18);
        close_out();
    end
endmodule // rsw_reset_state_bench
